// [pkg/phy_regs_pkg.sv]
// Shared constants and types of the transceiver control and status bank
package phy_regs_pkg;

   // Byte offsets on the two-wire serial interface
   localparam logic [7:0] LINE_CTRL_SET_ADDR = 8'h06;
   localparam logic [7:0] LINE_CTRL_CLR_ADDR = 8'h07;
   localparam logic [7:0] LIVE_STATUS_ADDR = 8'h08;
   localparam logic [7:0] PWR_CTRL_SET_ADDR = 8'h12;
   localparam logic [7:0] PWR_CTRL_CLR_ADDR = 8'h13;

   // Reset values of control registers, and the value read at unmapped offsets
   localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
   localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Line and VBUS control fields
   localparam int POS_LINE_PULLUP_BIT = 0;
   localparam int NEG_LINE_PULLUP_BIT = 1;
   localparam int POS_LINE_PULLDOWN_BIT = 2;
   localparam int NEG_LINE_PULLDOWN_BIT = 3;
   localparam int IDENT_PIN_TIE_LOW_BIT = 4;
   localparam int VBUS_PUMP_DRIVE_BIT = 5;
   localparam int VBUS_DISCHARGE_BIT = 6;
   localparam int VBUS_CHARGE_BIT = 7;

   // Power and auxiliary control fields
   localparam int POWER_DOWN_REQUEST_BIT = 0;
   localparam int PUMP_DISABLE_BIT = 1;
   localparam int IDENT_COMPARATORS_DISABLE_BIT = 2;
   localparam int CARKIT_LEVEL_SELECT_BIT = 3;
   localparam int SESS_END_REPORT_BIT = 4;
   localparam int PUMP_EXT_CLOCK_BIT = 5;
   localparam int IDENT_STRONG_PULLUP_BIT = 6;
   localparam int SCL_BIDIR_BIT = 7;

   // Live status fields
   localparam int ST_VBUS_VALID_BIT = 0;
   localparam int ST_SESS_VALID_BIT = 1;
   localparam int ST_POS_LINE_HIGH_BIT = 2;
   localparam int ST_IDENT_PIN_GROUNDED_BIT = 3;
   localparam int ST_NEG_LINE_HIGH_BIT = 4;
   localparam int ST_IDENT_PIN_OPEN_BIT = 5;
   localparam int ST_ATTACH_OR_SESS_END_BIT = 6;
   localparam int ST_CARKIT_PULSE_SEEN_BIT = 7;

   // Serial bit counter value at the end of a byte
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Synchronised input vector layout
   localparam int SYNC_WIDTH = 11;
   localparam int IN_SCL = 0;
   localparam int IN_SDA = 1;
   localparam int IN_VBUS_VALID = 2;
   localparam int IN_SESS_VALID = 3;
   localparam int IN_SESS_END = 4;
   localparam int IN_POS_LINE = 5;
   localparam int IN_NEG_LINE = 6;
   localparam int IN_IDENT_GND = 7;
   localparam int IN_IDENT_OPEN = 8;
   localparam int IN_CARKIT_LOW = 9;
   localparam int IN_CARKIT_HIGH = 10;
   // Bus idle high and no single-ended zero while the flops fill
   localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 11'h063;

   typedef enum logic [3:0]
   {
      SER_IDLE = 4'b0000,
      SER_ADDR = 4'b0001,
      SER_ADDR_ACK = 4'b0010,
      SER_REG = 4'b0011,
      SER_REG_ACK = 4'b0100,
      SER_WDATA = 4'b0101,
      SER_WDATA_ACK = 4'b0110,
      SER_RDATA = 4'b0111,
      SER_RDATA_ACK = 4'b1000
   } ser_state_e;

endpackage

// [hw/level_sync.sv]
// Two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/10ps
module level_sync
   import phy_regs_pkg::*;
#(
   parameter int WIDTH = 1,
   // Idle level of each pin, so no false edge follows reset
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed
   {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s st_ff;
   sync_s nxt_st;

   if (WIDTH < 1)
   begin : g_bad_width
      $error("level_sync needs WIDTH of at least 1");
   end

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.meta = async_in;
      // First stage feeds only the second
      nxt_st.stable = st_ff.meta;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_ff <= '{meta: RESET_VAL, stable: RESET_VAL};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.stable;

endmodule

// [hw/otg_phy_control_status_regs.sv]
// Control and live status registers of the transceiver, serial slave access
//
// Operation
// - Line control at 0x06/0x07; bit0 positive pull-up
// - Bit1 connects negative line pull-up
// - Bits 2 and 3 connect line pull-downs
// - Bit4 ties identification pin to ground
// - Bit5 powers VBUS from charge pump
// - Bit6 discharges VBUS through resistor
// - Bit7 charges VBUS through resistor
// - Power control at 0x12/0x13; bit0 power-down
// - Bit1 switches the charge pump off
// - Bit2 disables ID comparators, pull-up stays
// - Bit3 picks car-kit level low or high
// - Bit4 routes session end to status bit6 while attach is disabled
// - Bit5 selects external pump oscillator
// - Bit6 selects strong identification pull-up
// - Bit7 makes serial clock line bidirectional
// - Read-only live status at 0x08
// - Status bit0 shows VBUS valid
// - Status bit1 shows session valid
// - Status bits 2 and 4 show line levels
// - Status bit6 shows attach after SE0
// - Status bit6 shows session end when routed and attach is disabled
// - Status bit7 shows car-kit pulse detection
// - Set address sets ones, clear address clears
// - Set and clear addresses read same contents
// - Attach pull-up on SE0 and flag it
`timescale 1ns/10ps
module otg_phy_control_status_regs
   import phy_regs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2D
)
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic SCL_IN,
   output logic SCL_BIDIR_EN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic DISC_ATTACH_EN,
   input wire logic VBUS_VALID_CMP,
   input wire logic SESS_VALID_CMP,
   input wire logic SESS_END_CMP,
   input wire logic POS_LINE_LEVEL,
   input wire logic NEG_LINE_LEVEL,
   input wire logic IDENT_GND_CMP,
   input wire logic IDENT_OPEN_CMP,
   input wire logic CARKIT_LOW_CMP,
   input wire logic CARKIT_HIGH_CMP,
   output logic POS_LINE_PULLUP,
   output logic NEG_LINE_PULLUP,
   output logic POS_LINE_PULLDOWN,
   output logic NEG_LINE_PULLDOWN,
   output logic IDENT_PIN_TIE_LOW,
   output logic VBUS_PUMP_DRIVE,
   output logic VBUS_DISCHARGE,
   output logic VBUS_CHARGE,
   output logic POWER_DOWN_REQUEST,
   output logic PUMP_DISABLE,
   output logic IDENT_COMPARATORS_DISABLE,
   output logic CARKIT_LEVEL_SELECT,
   output logic PUMP_EXT_CLOCK,
   output logic IDENT_STRONG_PULLUP,
   output logic ATTACH_EVENT
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed
   {
      ser_state_e state;
      logic scl_q;
      logic sda_q;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] reg_ptr;
      logic rd_mode;
      logic master_ack;
      logic sda_oe;
      logic [7:0] line_ctrl;
      logic [7:0] pwr_ctrl;
      logic [7:0] status;
      logic attached;
      logic attach_evt;
      logic pos_pullup;
   } regs_s;

   regs_s st_ff;
   regs_s nxt_st;
   logic [SYNC_WIDTH-1:0] sync_in;

   // Addresses 0..7 and 0x78..0x7F are reserved on the serial bus
   if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77)
   begin : g_bad_addr
      $error("DEV_ADDR lies in a reserved serial address range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   level_sync #(.WIDTH(SYNC_WIDTH), .RESET_VAL(SYNC_RESET)) u_sync
   (
      .clk(CLK),
      .nrst(NRST),
      .async_in({CARKIT_HIGH_CMP, CARKIT_LOW_CMP, IDENT_OPEN_CMP,
                 IDENT_GND_CMP, NEG_LINE_LEVEL, POS_LINE_LEVEL,
                 SESS_END_CMP, SESS_VALID_CMP, VBUS_VALID_CMP,
                 SDA_IN, SCL_IN}),
      .sync_out(sync_in)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register access helpers

   function automatic logic [7:0] read_byte(input logic [7:0] addr,
                                            input regs_s s);
      logic [7:0] v;
      v = UNMAPPED_READ;
      case (addr)
         LINE_CTRL_SET_ADDR, LINE_CTRL_CLR_ADDR: v = s.line_ctrl;
         PWR_CTRL_SET_ADDR, PWR_CTRL_CLR_ADDR: v = s.pwr_ctrl;
         LIVE_STATUS_ADDR: v = s.status;
         default: v = UNMAPPED_READ;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next state

   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic se0;
   logic [7:0] rbyte;
   logic [7:0] live;

   assign scl = sync_in[IN_SCL];
   assign sda = sync_in[IN_SDA];
   assign scl_rise = scl & ~st_ff.scl_q;
   assign scl_fall = ~scl & st_ff.scl_q;
   assign start_cond = scl & st_ff.scl_q & st_ff.sda_q & ~sda;
   assign stop_cond = scl & st_ff.scl_q & ~st_ff.sda_q & sda;
   assign se0 = ~sync_in[IN_POS_LINE] & ~sync_in[IN_NEG_LINE];
   assign rbyte = read_byte(st_ff.reg_ptr, st_ff);

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.scl_q = scl;
      nxt_st.sda_q = sda;
      nxt_st.attach_evt = 1'b0;

      // Serial slave: address, register pointer, then data bytes
      if (stop_cond)
      begin
         nxt_st.state = SER_IDLE;
         nxt_st.sda_oe = 1'b0;
      end
      else if (start_cond)
      begin
         // Repeated start keeps the pointer for a following read
         nxt_st.state = SER_ADDR;
         nxt_st.bitcnt = 4'h0;
         nxt_st.sda_oe = 1'b0;
      end
      else
      begin
         case (st_ff.state)
            SER_IDLE: nxt_st.sda_oe = 1'b0;
            SER_ADDR, SER_REG, SER_WDATA:
            begin
               if (scl_rise)
               begin
                  nxt_st.shreg = {st_ff.shreg[6:0], sda};
                  nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
               end
               else if (scl_fall && st_ff.bitcnt == BITS_PER_BYTE)
               begin
                  nxt_st.sda_oe = 1'b1;
                  if (st_ff.state == SER_ADDR)
                  begin
                     if (st_ff.shreg[7:1] == DEV_ADDR)
                     begin
                        nxt_st.rd_mode = st_ff.shreg[0];
                        nxt_st.state = SER_ADDR_ACK;
                     end
                     else
                     begin
                        nxt_st.sda_oe = 1'b0;
                        nxt_st.state = SER_IDLE;
                     end
                  end
                  else if (st_ff.state == SER_REG)
                  begin
                     nxt_st.reg_ptr = st_ff.shreg;
                     nxt_st.state = SER_REG_ACK;
                  end
                  else
                  begin
                     case (st_ff.reg_ptr)
                        LINE_CTRL_SET_ADDR:
                           nxt_st.line_ctrl = st_ff.line_ctrl
                                              | st_ff.shreg;
                        LINE_CTRL_CLR_ADDR:
                           nxt_st.line_ctrl = st_ff.line_ctrl
                                              & ~st_ff.shreg;
                        PWR_CTRL_SET_ADDR:
                           nxt_st.pwr_ctrl = st_ff.pwr_ctrl
                                             | st_ff.shreg;
                        PWR_CTRL_CLR_ADDR:
                           nxt_st.pwr_ctrl = st_ff.pwr_ctrl
                                             & ~st_ff.shreg;
                        // Status and unmapped offsets ignore writes
                        default: nxt_st.line_ctrl = st_ff.line_ctrl;
                     endcase
                     nxt_st.reg_ptr = st_ff.reg_ptr + 8'h01;
                     nxt_st.state = SER_WDATA_ACK;
                  end
               end
            end
            SER_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  nxt_st.bitcnt = 4'h0;
                  if (st_ff.rd_mode)
                  begin
                     nxt_st.shreg = rbyte;
                     nxt_st.reg_ptr = st_ff.reg_ptr + 8'h01;
                     nxt_st.sda_oe = ~rbyte[7];
                     nxt_st.state = SER_RDATA;
                  end
                  else
                  begin
                     nxt_st.sda_oe = 1'b0;
                     nxt_st.state = SER_REG;
                  end
               end
            end
            SER_REG_ACK, SER_WDATA_ACK:
            begin
               if (scl_fall)
               begin
                  nxt_st.sda_oe = 1'b0;
                  nxt_st.bitcnt = 4'h0;
                  nxt_st.state = SER_WDATA;
               end
            end
            SER_RDATA:
            begin
               if (scl_rise)
                  nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
               else if (scl_fall)
               begin
                  if (st_ff.bitcnt == BITS_PER_BYTE)
                  begin
                     nxt_st.sda_oe = 1'b0;
                     nxt_st.state = SER_RDATA_ACK;
                  end
                  else
                  begin
                     nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
                     nxt_st.sda_oe = ~st_ff.shreg[6];
                  end
               end
            end
            SER_RDATA_ACK:
            begin
               if (scl_rise)
                  nxt_st.master_ack = ~sda;
               else if (scl_fall)
               begin
                  nxt_st.bitcnt = 4'h0;
                  // Master NACK ends the read; wait for stop
                  if (st_ff.master_ack)
                  begin
                     nxt_st.shreg = rbyte;
                     nxt_st.reg_ptr = st_ff.reg_ptr + 8'h01;
                     nxt_st.sda_oe = ~rbyte[7];
                     nxt_st.state = SER_RDATA;
                  end
                  else
                     nxt_st.state = SER_IDLE;
               end
            end
            default:
            begin
               nxt_st.state = SER_IDLE;
               nxt_st.sda_oe = 1'b0;
            end
         endcase
      end

      // Automatic attach after SE0 while the feature is enabled
      if (!DISC_ATTACH_EN)
         nxt_st.attached = 1'b0;
      else if (se0 && !st_ff.attached)
      begin
         nxt_st.attached = 1'b1;
         nxt_st.attach_evt = 1'b1;
      end
      nxt_st.pos_pullup = nxt_st.line_ctrl[POS_LINE_PULLUP_BIT]
                          | nxt_st.attached;

      // Live status, one clock behind the synchronised inputs
      live[ST_VBUS_VALID_BIT] = sync_in[IN_VBUS_VALID];
      live[ST_SESS_VALID_BIT] = sync_in[IN_SESS_VALID];
      live[ST_POS_LINE_HIGH_BIT] = sync_in[IN_POS_LINE];
      live[ST_NEG_LINE_HIGH_BIT] = sync_in[IN_NEG_LINE];
      // Disabled ID comparators report nothing
      live[ST_IDENT_PIN_GROUNDED_BIT] = sync_in[IN_IDENT_GND]
         & ~st_ff.pwr_ctrl[IDENT_COMPARATORS_DISABLE_BIT];
      live[ST_IDENT_PIN_OPEN_BIT] = sync_in[IN_IDENT_OPEN]
         & ~st_ff.pwr_ctrl[IDENT_COMPARATORS_DISABLE_BIT];
      live[ST_ATTACH_OR_SESS_END_BIT] = DISC_ATTACH_EN ? st_ff.attached
         : sync_in[IN_SESS_END]
         & st_ff.pwr_ctrl[SESS_END_REPORT_BIT];
      live[ST_CARKIT_PULSE_SEEN_BIT] =
         st_ff.pwr_ctrl[CARKIT_LEVEL_SELECT_BIT]
         ? sync_in[IN_CARKIT_HIGH] : sync_in[IN_CARKIT_LOW];
      nxt_st.status = live;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         st_ff <= '{state: SER_IDLE, scl_q: 1'b1, sda_q: 1'b1,
                    bitcnt: 4'h0, shreg: 8'h00, reg_ptr: 8'h00,
                    rd_mode: 1'b0, master_ack: 1'b0, sda_oe: 1'b0,
                    line_ctrl: LINE_CTRL_RESET, pwr_ctrl: PWR_CTRL_RESET,
                    status: 8'h00, attached: 1'b0, attach_evt: 1'b0,
                    pos_pullup: 1'b0};
      end
      else
         st_ff <= nxt_st;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign SDA_OUT = 1'b0;
   assign SDA_OE = st_ff.sda_oe;
   // Slave never stretches; bit only sets the pad direction
   assign SCL_BIDIR_EN = st_ff.pwr_ctrl[SCL_BIDIR_BIT];
   assign POS_LINE_PULLUP = st_ff.pos_pullup;
   assign NEG_LINE_PULLUP = st_ff.line_ctrl[NEG_LINE_PULLUP_BIT];
   assign POS_LINE_PULLDOWN = st_ff.line_ctrl[POS_LINE_PULLDOWN_BIT];
   assign NEG_LINE_PULLDOWN = st_ff.line_ctrl[NEG_LINE_PULLDOWN_BIT];
   assign IDENT_PIN_TIE_LOW = st_ff.line_ctrl[IDENT_PIN_TIE_LOW_BIT];
   assign VBUS_PUMP_DRIVE = st_ff.line_ctrl[VBUS_PUMP_DRIVE_BIT];
   assign VBUS_DISCHARGE = st_ff.line_ctrl[VBUS_DISCHARGE_BIT];
   assign VBUS_CHARGE = st_ff.line_ctrl[VBUS_CHARGE_BIT];
   assign POWER_DOWN_REQUEST = st_ff.pwr_ctrl[POWER_DOWN_REQUEST_BIT];
   assign PUMP_DISABLE = st_ff.pwr_ctrl[PUMP_DISABLE_BIT];
   assign IDENT_COMPARATORS_DISABLE =
      st_ff.pwr_ctrl[IDENT_COMPARATORS_DISABLE_BIT];
   assign CARKIT_LEVEL_SELECT = st_ff.pwr_ctrl[CARKIT_LEVEL_SELECT_BIT];
   assign PUMP_EXT_CLOCK = st_ff.pwr_ctrl[PUMP_EXT_CLOCK_BIT];
   assign IDENT_STRONG_PULLUP = st_ff.pwr_ctrl[IDENT_STRONG_PULLUP_BIT];
   assign ATTACH_EVENT = st_ff.attach_evt;

endmodule

// [testbench/otg_phy_regs_monitor.sv]
// Port-level checks of the serial register bank
`timescale 1ns/10ps
module otg_phy_regs_monitor
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic SCL_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic DISC_ATTACH_EN,
   input wire logic POS_LINE_PULLUP,
   input wire logic NEG_LINE_PULLUP,
   input wire logic VBUS_CHARGE,
   input wire logic POWER_DOWN_REQUEST,
   input wire logic SCL_BIDIR_EN,
   input wire logic ATTACH_EVENT
);
   default clocking mon_cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   ////////////////////////////////////////
   // Control outputs other than the positive pull-up may only move inside the device's acknowledge bit
   sequence s_ack_bit;
      SDA_OE || $past(SDA_OE);
   endsequence
   sequence s_pullup_soon;
      ##[0:2] POS_LINE_PULLUP;
   endsequence
   sequence s_clock_high;
      SCL_IN [*4];
   endsequence
   ////////////////////////////////////////
   a_sda_open_drain: assert property (SDA_OUT == 1'b0)
      else $error("data output value not zero");
   a_reset_quiet: assert property ($rose(NRST) |-> !SDA_OE &&
      !POS_LINE_PULLUP && !VBUS_CHARGE && !SCL_BIDIR_EN && !ATTACH_EVENT)
      else $error("output active right after reset");
   a_line_ctrl_quiet: assert property
      ($changed({NEG_LINE_PULLUP, VBUS_CHARGE}) |-> s_ack_bit)
      else $error("line control moved outside a write");
   a_pwr_ctrl_quiet: assert property
      ($changed({POWER_DOWN_REQUEST, SCL_BIDIR_EN}) |-> s_ack_bit)
      else $error("power control moved outside a write");
   a_data_steady: assert property (s_clock_high |-> $stable(SDA_OE))
      else $error("data line moved while clock high");
   a_attach_pulse: assert property (ATTACH_EVENT |=> !ATTACH_EVENT)
      else $error("attach event longer than one cycle");
   a_attach_enabled: assert property
      (ATTACH_EVENT |-> $past(DISC_ATTACH_EN))
      else $error("attach event while attach disabled");
   a_attach_pullup: assert property (ATTACH_EVENT |-> s_pullup_soon)
      else $error("attach without positive pull-up");
endmodule

bind otg_phy_control_status_regs otg_phy_regs_monitor u_otg_phy_regs_monitor
(
   .CLK, .NRST, .SCL_IN, .SDA_OUT, .SDA_OE, .DISC_ATTACH_EN,
   .POS_LINE_PULLUP, .NEG_LINE_PULLUP, .VBUS_CHARGE,
   .POWER_DOWN_REQUEST, .SCL_BIDIR_EN, .ATTACH_EVENT
);

// [testbench/host_serial_model.sv]
// Behavioural two-wire serial host that reaches the register bank
`timescale 1ns/10ps
module host_serial_model
#(
   parameter logic [6:0] ADDR = 7'h2D
)
(
   input wire logic clk,
   input wire logic sda_wire,
   output logic scl,
   output logic sda_drive
);
   int slow = 0;
   // Clock stands high between frames; data released to the pull-up
   initial
   begin
      scl = 1'b1;
      sda_drive = 1'b1;
   end
   ////////////////////////////////////////
   task automatic half(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Data moves one cycle after the clock falls so no false start is seen
   task automatic xfer_bit(input logic b, output logic r);
      half(1);
      sda_drive = b;
      half(3 + slow);
      scl = 1'b1;
      half(4);
      r = sda_wire;
      scl = 1'b0;
   endtask
   task automatic xfer_byte(input logic [7:0] d, output logic [7:0] r,
                            output logic ack_in);
      for (int i = 7; i >= 0; i--)
         xfer_bit(d[i], r[i]);
      xfer_bit(1'b1, ack_in);
   endtask
   task automatic start_cond();
      half(4);
      sda_drive = 1'b1;
      half(3);
      scl = 1'b1;
      half(4);
      sda_drive = 1'b0;
      half(4);
      scl = 1'b0;
   endtask
   task automatic stop_cond();
      half(1);
      sda_drive = 1'b0;
      half(3);
      scl = 1'b1;
      half(4);
      sda_drive = 1'b1;
      half(4);
   endtask
   ////////////////////////////////////////
   task automatic probe(input logic [6:0] a, output logic nack);
      logic [7:0] r;
      start_cond();
      xfer_byte({a, 1'b0}, r, nack);
      stop_cond();
   endtask
   task automatic write_reg(input logic [7:0] p, d, output logic nack);
      logic [7:0] r;
      logic n0, n1, n2;
      start_cond();
      xfer_byte({ADDR, 1'b0}, r, n0);
      xfer_byte(p, r, n1);
      xfer_byte(d, r, n2);
      stop_cond();
      nack = n0 | n1 | n2;
   endtask
   // Single-byte read ends with our own refusal, then stop
   task automatic read_reg(input logic [7:0] p, output logic [7:0] d,
                           output logic nack);
      logic [7:0] r;
      logic n0, n1, n2, n3;
      start_cond();
      xfer_byte({ADDR, 1'b0}, r, n0);
      xfer_byte(p, r, n1);
      start_cond();
      xfer_byte({ADDR, 1'b1}, r, n2);
      xfer_byte(8'hFF, d, n3);
      stop_cond();
      nack = n0 | n1 | n2;
   endtask
endmodule

// [testbench/otg_phy_control_status_regs_test.sv]
// Self-checking bench for the transceiver control and status bank
`timescale 1ns/10ps
module otg_phy_control_status_regs_test;
   import phy_regs_pkg::*;
   localparam logic [6:0] DEV = 7'h2D;
   logic CLK, NRST, SCL_IN, SDA_IN, DISC_ATTACH_EN, SCL_BIDIR_EN, SDA_OUT;
   logic VBUS_VALID_CMP, SESS_VALID_CMP, SESS_END_CMP, POS_LINE_LEVEL;
   logic NEG_LINE_LEVEL, IDENT_GND_CMP, IDENT_OPEN_CMP, CARKIT_LOW_CMP;
   logic CARKIT_HIGH_CMP, SDA_OE, POS_LINE_PULLUP, NEG_LINE_PULLUP;
   logic POS_LINE_PULLDOWN, NEG_LINE_PULLDOWN, IDENT_PIN_TIE_LOW;
   logic VBUS_PUMP_DRIVE, VBUS_DISCHARGE, VBUS_CHARGE, POWER_DOWN_REQUEST;
   logic PUMP_DISABLE, IDENT_COMPARATORS_DISABLE, CARKIT_LEVEL_SELECT;
   logic PUMP_EXT_CLOCK, IDENT_STRONG_PULLUP, ATTACH_EVENT, sda_m, ack;
   logic [8:0] cmp;
   logic [7:0] line_m, pwr_m, a;
   int n_mismatch, comparisons, n_attach;
   logic [7:0] addr_tab [4] = '{LINE_CTRL_SET_ADDR, LINE_CTRL_CLR_ADDR,
                                PWR_CTRL_SET_ADDR, PWR_CTRL_CLR_ADDR};
   wire logic [7:0] line_o = {VBUS_CHARGE, VBUS_DISCHARGE, VBUS_PUMP_DRIVE,
      IDENT_PIN_TIE_LOW, NEG_LINE_PULLDOWN, POS_LINE_PULLDOWN,
      NEG_LINE_PULLUP, POS_LINE_PULLUP};
   // Session-end reporting bit has no pin, so it is masked out here
   wire logic [7:0] pwr_o = {SCL_BIDIR_EN, IDENT_STRONG_PULLUP,
      PUMP_EXT_CLOCK, 1'b0, CARKIT_LEVEL_SELECT, IDENT_COMPARATORS_DISABLE,
      PUMP_DISABLE, POWER_DOWN_REQUEST};
   assign {CARKIT_HIGH_CMP, CARKIT_LOW_CMP, IDENT_OPEN_CMP, IDENT_GND_CMP,
      NEG_LINE_LEVEL, POS_LINE_LEVEL, SESS_END_CMP, SESS_VALID_CMP,
      VBUS_VALID_CMP} = cmp;
   // Open-drain wire: pulled up unless either side pulls it low
   assign SDA_IN = sda_m & ~SDA_OE;
   otg_phy_control_status_regs #(.DEV_ADDR(DEV))
      u_otg_phy_control_status_regs (.*);
   host_serial_model #(.ADDR(DEV)) u_host_serial_model
      (.clk(CLK), .sda_wire(SDA_IN), .scl(SCL_IN), .sda_drive(sda_m));
   ////////////////////////////////////////
   initial
   begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   always @(posedge CLK)
      if (ATTACH_EVENT === 1'b1)
         n_attach++;
   initial
   begin
      repeat (100000) @(posedge CLK);
      n_mismatch++;
      tally_and_finish();
   end
   ////////////////////////////////////////
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] status_exp(input logic att);
      status_exp = {pwr_m[3] ? cmp[8] : cmp[7],
         DISC_ATTACH_EN ? att : cmp[2] & pwr_m[4], cmp[6] & ~pwr_m[2],
         cmp[4], cmp[5] & ~pwr_m[2], cmp[3], cmp[1], cmp[0]};
   endfunction
   task automatic chk_outs();
      check(line_o, line_m);
      check(pwr_o, pwr_m & 8'hEF);
   endtask
   task automatic do_reset();
      NRST = 1'b0;
      repeat (12) @(negedge CLK);
      NRST = 1'b1;
      line_m = LINE_CTRL_RESET;
      pwr_m = PWR_CTRL_RESET;
      repeat (4) @(negedge CLK);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      logic nack;
      u_host_serial_model.write_reg(ad, d, nack);
      check({7'h00, nack}, 8'h00);
      case (ad)
         LINE_CTRL_SET_ADDR: line_m |= d;
         LINE_CTRL_CLR_ADDR: line_m &= ~d;
         PWR_CTRL_SET_ADDR: pwr_m |= d;
         PWR_CTRL_CLR_ADDR: pwr_m &= ~d;
         default: ;
      endcase
      repeat (2) @(negedge CLK);
      chk_outs();
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
      logic nack;
      logic [7:0] v;
      u_host_serial_model.read_reg(ad, v, nack);
      check({7'h00, nack}, 8'h00);
      check(v, exp);
   endtask
   ////////////////////////////////////////
   initial
   begin
      cmp = 9'h000;
      DISC_ATTACH_EN = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      n_attach = 0;
      void'($urandom(32'h9aef0693));
      do_reset();
      chk_outs();
      rd(LINE_CTRL_SET_ADDR, 8'h00);
      rd(PWR_CTRL_CLR_ADDR, 8'h00);
      wr(LINE_CTRL_SET_ADDR, 8'hFF);
      wr(PWR_CTRL_SET_ADDR, 8'hFF);
      for (int i = 0; i < 16; i++)
      begin
         a = addr_tab[i % 4];
         u_host_serial_model.slow = (i % 3 == 0) ? 6 : 0;
         wr(a, 8'($urandom()));
         rd(a, a[4] ? pwr_m : line_m);
         rd(a ^ 8'h01, a[4] ? pwr_m : line_m);
      end
      // Status is read-only and unmapped space reads as zero
      wr(LIVE_STATUS_ADDR, 8'hFF);
      rd(8'h20, UNMAPPED_READ);
      for (int i = 0; i < 8; i++)
      begin
         cmp = 9'($urandom());
         wr(PWR_CTRL_CLR_ADDR, 8'h1C);
         wr(PWR_CTRL_SET_ADDR, 8'($urandom()) & 8'h1C);
         rd(LIVE_STATUS_ADDR, status_exp(1'b0));
      end
      u_host_serial_model.probe(DEV ^ 7'h01, ack);
      check({7'h00, ack}, 8'h01);
      rd(PWR_CTRL_SET_ADDR, pwr_m);
      // Both lines fall to zero with attach enabled
      wr(LINE_CTRL_CLR_ADDR, 8'hFF);
      cmp = 9'h018;
      repeat (4) @(negedge CLK);
      n_attach = 0;
      DISC_ATTACH_EN = 1'b1;
      repeat (8) @(negedge CLK);
      check(8'(n_attach), 8'h00);
      cmp = 9'h000;
      repeat (10) @(negedge CLK);
      check(8'(n_attach), 8'h01);
      check({7'h00, POS_LINE_PULLUP}, 8'h01);
      rd(LIVE_STATUS_ADDR, status_exp(1'b1));
      DISC_ATTACH_EN = 1'b0;
      repeat (4) @(negedge CLK);
      chk_outs();
      wr(PWR_CTRL_SET_ADDR, 8'hA5);
      do_reset();
      chk_outs();
      rd(PWR_CTRL_SET_ADDR, 8'h00);
      tally_and_finish();
   end
endmodule
